// *** dpgi_cfg.svh ***
// Purpose: constants for the dual-port event interrupt logic
// Assumes: 10 MHz system clock
// Notes:   one-hot state codes and field positions live here
`ifndef DPGI_CFG_SVH
`define DPGI_CFG_SVH

// ------------------------------------------------------------
// channel numbering
// ------------------------------------------------------------
`define DPGI_NUM_CH        4
`define DPGI_CH_SRQ_A      0
`define DPGI_CH_PORT_A     1
`define DPGI_CH_MONITOR    2
`define DPGI_CH_PORT_B     3

// ------------------------------------------------------------
// interrupt level and vectors
// ------------------------------------------------------------
`define DPGI_LEVEL_W       3
`define DPGI_LEVEL_RST     3'h0
`define DPGI_VEC_W         8
`define DPGI_VEC_RST       8'h0f

// ------------------------------------------------------------
// bus error state codes (one-hot)
// ------------------------------------------------------------
`define DPGI_BE_IDLE       2'h1
`define DPGI_BE_HELD       2'h2

`endif

// *** dpgi_pkg.sv ***
// Purpose: shared types for the dual-port event interrupt logic
// Assumes: dpgi_cfg.svh included before use
// Notes:   no constants here except through the header
`include "dpgi_cfg.svh"

package dpgi_pkg;

  // per-port event sources feeding one status line
  typedef struct packed {
    logic ctrl_int;
    logic bus_err;
    logic sync_done;
  } dpgi_evt_t;

  // per-channel view from software
  typedef struct packed {
    logic line_level_status;
    logic line_transition_flag;
    logic operation_complete_flag;
    logic error_flag;
  } dpgi_chan_stat_t;

  typedef enum logic [1:0] {
    DPGI_BE_IDLE = `DPGI_BE_IDLE,
    DPGI_BE_HELD = `DPGI_BE_HELD
  } dpgi_be_state_t;

endpackage

// *** dpgi_chan.sv ***
// Purpose: one dma controller channel status line: sync, edge, flags
// Assumes: line input is asynchronous, active low
// Notes:   set of a flag wins over a clear in the same cycle
`timescale 1ns/1ps

module dpgi_chan (
  // clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rst_b_in,
  // line and events
  input  wire logic line_b_in,
  input  wire logic complete_in,
  input  wire logic error_in,
  // software controls
  input  wire logic int_en_in,
  input  wire logic clr_transition_in,
  input  wire logic clr_complete_in,
  input  wire logic clr_error_in,
  // status
  output dpgi_pkg::dpgi_chan_stat_t stat_out,
  output logic      irq_out
);

  logic [1:0] sync_ff;
  logic       level_ff;
  logic       trans_ff;
  logic       fin_ff;
  logic       err_ff;
  wire        fall_pulse;

  // ------------------------------------------------------------
  // synchroniser and edge
  // ------------------------------------------------------------
  assign fall_pulse = level_ff & ~sync_ff[1];

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      sync_ff  <= 2'h3;
      level_ff <= 1'h1;
    end else begin
      sync_ff  <= {sync_ff[0], line_b_in};
      level_ff <= sync_ff[1];
    end
  end

  // ------------------------------------------------------------
  // sticky flags
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      trans_ff <= 1'h0;
      fin_ff   <= 1'h0;
      err_ff   <= 1'h0;
    end else begin
      trans_ff <= fall_pulse | (trans_ff & ~clr_transition_in);
      fin_ff   <= complete_in | (fin_ff & ~clr_complete_in);
      err_ff   <= error_in | (err_ff & ~clr_error_in);
    end
  end

  assign stat_out.line_level_status       = level_ff;
  assign stat_out.line_transition_flag    = trans_ff;
  assign stat_out.operation_complete_flag = fin_ff;
  assign stat_out.error_flag              = err_ff;

  // request held until both the transition and complete flags are cleared
  assign irq_out = int_en_in & (trans_ff | fin_ff);

endmodule // dpgi_chan

// *** dpgi_top.sv ***
// Purpose: per-port event aggregation and shared bus interrupt request
// Assumes: one 10 MHz clock, synchronous active-low reset
// Notes:   channel status line polarity is active low throughout
//
// Functional notes
// - each port ORs controller interrupt, bus error and sync done onto one line
// - port A drives channel 1 line, port B drives channel 3 line
// - request level comes from each port config register, levels 1 to 7
// - both ports share a single bus interrupt request line
// - line level status shows the synchronised line level
// - falling edge on a line sets its transition flag
// - each channel has its own interrupt enable for transition flag
// - controller interrupt reaches the bus only through the status line
// - bus error pulls the line of the port active at the error
// - completion waits for bus sync, then pulls the port line low
// - any config register write releases that port's sync event
// - bus error line releases when the slave drops bus error
// - acknowledge returns error vector if error flag set, else normal
// - request stays asserted until both transition and complete flags are cleared
// - reading a controller status register clears all its bits
// - second status register is read before the first
// - channel 0 line follows port A service request, active low
// - channel 2 line follows port A remote enable or port B request by switch
// - channel 0 bus error sets channel 0 error flag and channel 1 transition
// - channel requests on complete or transition flag when enabled
`timescale 1ns/1ps
`include "dpgi_cfg.svh"

module dpgi_top #(
  parameter int NUM_CH = `DPGI_NUM_CH
) (
  // clock and reset
  input  wire logic                       clk_sys_in,
  input  wire logic                       rst_b_in,
  // port event sources (controller interrupts are levels from read-clear status)
  input  wire logic                       ctrl_int_a_in,
  input  wire logic                       ctrl_int_b_in,
  input  wire logic                       xfer_done_a_in,
  input  wire logic                       xfer_done_b_in,
  input  wire logic                       bus_sync_a_in,
  input  wire logic                       bus_sync_b_in,
  // dma bus error and active channel
  input  wire logic                       bus_err_b_in,
  input  wire logic [1:0]                 active_ch_in,
  input  wire logic [NUM_CH-1:0]          ch_complete_in,
  // gpib lines for monitor channels
  input  wire logic                       srq_a_b_in,
  input  wire logic                       ren_a_b_in,
  input  wire logic                       srq_b_b_in,
  input  wire logic                       monitor_sel_in,
  // configuration writes
  input  wire logic                       cfg_a_wr_in,
  input  wire logic                       cfg_b_wr_in,
  input  wire logic [`DPGI_LEVEL_W-1:0]   cfg_a_level_in,
  input  wire logic [`DPGI_LEVEL_W-1:0]   cfg_b_level_in,
  // channel controls
  input  wire logic [NUM_CH-1:0]          int_en_in,
  input  wire logic [NUM_CH-1:0]          clr_transition_in,
  input  wire logic [NUM_CH-1:0]          clr_complete_in,
  input  wire logic [NUM_CH-1:0]          clr_error_in,
  input  wire logic [`DPGI_VEC_W-1:0]     normal_vector_in [NUM_CH],
  input  wire logic [`DPGI_VEC_W-1:0]     error_vector_in [NUM_CH],
  // bus interrupt
  input  wire logic                       iack_in,
  output logic                            irq_out,
  output logic [`DPGI_LEVEL_W-1:0]        irq_level_out,
  output logic [`DPGI_VEC_W-1:0]          vector_out,
  output logic                            vector_valid_out,
  // status
  output dpgi_pkg::dpgi_chan_stat_t       chan_stat_out [NUM_CH],
  output logic                            port_a_event_line_out,
  output logic                            port_b_event_line_out
);

  if (NUM_CH != 4) begin : g_bad_num_ch
    $error("dpgi_top serves exactly four channels");
  end

  // ------------------------------------------------------------
  // input synchronisers for port-side events
  // ------------------------------------------------------------
  logic [5:0] s1_ff;
  logic [5:0] s2_ff;
  wire  [5:0] raw = {ctrl_int_a_in, ctrl_int_b_in, xfer_done_a_in,
                     xfer_done_b_in, bus_sync_a_in, bus_err_b_in};

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      s1_ff <= 6'h01;
      s2_ff <= 6'h01;
    end else begin
      s1_ff <= raw;
      s2_ff <= s1_ff;
    end
  end

  logic bsync_b1_ff;
  logic bsync_b2_ff;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      bsync_b1_ff <= 1'h0;
      bsync_b2_ff <= 1'h0;
    end else begin
      bsync_b1_ff <= bus_sync_b_in;
      bsync_b2_ff <= bsync_b1_ff;
    end
  end

  // controller level is not latched, so the status reads release the line
  wire ctrl_a  = s2_ff[5];
  wire ctrl_b  = s2_ff[4];
  wire done_a  = s2_ff[3];
  wire done_b  = s2_ff[2];
  wire sync_a  = s2_ff[1];
  wire berr    = ~s2_ff[0];
  wire sync_b  = bsync_b2_ff;

  // ------------------------------------------------------------
  // bus error: latch the active port, hold until release
  // ------------------------------------------------------------
  dpgi_pkg::dpgi_be_state_t be_state_ff;
  dpgi_pkg::dpgi_be_state_t nxt_be_state;
  logic                     be_port_b_ff;
  logic [1:0]               be_ch_ff;
  wire                      be_start = (be_state_ff == dpgi_pkg::DPGI_BE_IDLE) & berr;

  always_comb begin
    case (be_state_ff)
      dpgi_pkg::DPGI_BE_IDLE: nxt_be_state = berr ? dpgi_pkg::DPGI_BE_HELD
                                                  : dpgi_pkg::DPGI_BE_IDLE;
      dpgi_pkg::DPGI_BE_HELD: nxt_be_state = berr ? dpgi_pkg::DPGI_BE_HELD
                                                  : dpgi_pkg::DPGI_BE_IDLE;
      default:                nxt_be_state = dpgi_pkg::DPGI_BE_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      be_state_ff  <= dpgi_pkg::DPGI_BE_IDLE;
      be_port_b_ff <= 1'h0;
      be_ch_ff     <= 2'h0;
    end else begin
      be_state_ff <= nxt_be_state;
      if (be_start) begin
        be_port_b_ff <= active_ch_in[1];
        be_ch_ff     <= active_ch_in;
      end
    end
  end

  wire be_held = (be_state_ff == dpgi_pkg::DPGI_BE_HELD);
  wire be_a    = be_held & ~be_port_b_ff;
  wire be_b    = be_held & be_port_b_ff;

  // ------------------------------------------------------------
  // sync event: set on done and synchronised, cleared by config write
  // ------------------------------------------------------------
  logic sync_evt_a_ff;
  logic sync_evt_b_ff;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      sync_evt_a_ff <= 1'h0;
      sync_evt_b_ff <= 1'h0;
    end else begin
      sync_evt_a_ff <= (done_a & sync_a) | (sync_evt_a_ff & ~cfg_a_wr_in);
      sync_evt_b_ff <= (done_b & sync_b) | (sync_evt_b_ff & ~cfg_b_wr_in);
    end
  end

  // ------------------------------------------------------------
  // config level registers
  // ------------------------------------------------------------
  logic [`DPGI_LEVEL_W-1:0] level_a_ff;
  logic [`DPGI_LEVEL_W-1:0] level_b_ff;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      level_a_ff <= `DPGI_LEVEL_RST;
      level_b_ff <= `DPGI_LEVEL_RST;
    end else begin
      if (cfg_a_wr_in) level_a_ff <= cfg_a_level_in;
      if (cfg_b_wr_in) level_b_ff <= cfg_b_level_in;
    end
  end

  // ------------------------------------------------------------
  // per-port event lines, active low
  // ------------------------------------------------------------
  dpgi_pkg::dpgi_evt_t evt_a;
  dpgi_pkg::dpgi_evt_t evt_b;
  assign evt_a = '{ctrl_int: ctrl_a, bus_err: be_a, sync_done: sync_evt_a_ff};
  assign evt_b = '{ctrl_int: ctrl_b, bus_err: be_b, sync_done: sync_evt_b_ff};

  logic port_a_event_line_ff;
  logic port_b_event_line_ff;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      port_a_event_line_ff <= 1'h1;
      port_b_event_line_ff <= 1'h1;
    end else begin
      port_a_event_line_ff <= ~(|evt_a);
      port_b_event_line_ff <= ~(|evt_b);
    end
  end
  assign port_a_event_line_out = port_a_event_line_ff;
  assign port_b_event_line_out = port_b_event_line_ff;

  wire monitor_line_two = monitor_sel_in ? srq_b_b_in : ren_a_b_in;

  wire [NUM_CH-1:0] line_b = {port_b_event_line_ff, monitor_line_two,
                              port_a_event_line_ff, srq_a_b_in};

  // ------------------------------------------------------------
  // channels
  // ------------------------------------------------------------
  logic [NUM_CH-1:0] ch_irq;
  logic [NUM_CH-1:0] ch_err_set;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
      // bus error flags only the channel that was active
      assign ch_err_set[gi] = be_start & (active_ch_in == 2'(gi));
      dpgi_chan u_chan (
        .clk_sys_in        (clk_sys_in),
        .rst_b_in          (rst_b_in),
        .line_b_in         (line_b[gi]),
        .complete_in       (ch_complete_in[gi]),
        .error_in          (ch_err_set[gi]),
        .int_en_in         (int_en_in[gi]),
        .clr_transition_in (clr_transition_in[gi]),
        .clr_complete_in   (clr_complete_in[gi]),
        .clr_error_in      (clr_error_in[gi]),
        .stat_out          (chan_stat_out[gi]),
        .irq_out           (ch_irq[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // shared request, level and vector
  // ------------------------------------------------------------
  // lowest numbered pending channel answers acknowledge
  wire [1:0] win_ch = ch_irq[0] ? 2'h0 : ch_irq[1] ? 2'h1 : ch_irq[2] ? 2'h2 : 2'h3;
  wire       win_b  = win_ch[1];
  wire       any    = |ch_irq;
  wire [`DPGI_VEC_W-1:0] win_vec = chan_stat_out[win_ch].error_flag
                                   ? error_vector_in[win_ch]
                                   : normal_vector_in[win_ch];

  logic [`DPGI_VEC_W-1:0] vector_ff;
  logic                   vvalid_ff;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      vector_ff <= `DPGI_VEC_RST;
      vvalid_ff <= 1'h0;
    end else begin
      vvalid_ff <= iack_in & any;
      if (iack_in & any) vector_ff <= win_vec;
    end
  end

  assign irq_out          = any;
  assign irq_level_out    = any ? (win_b ? level_b_ff : level_a_ff) : `DPGI_LEVEL_RST;
  assign vector_out       = vector_ff;
  assign vector_valid_out = vvalid_ff;

endmodule // dpgi_top

// *** dpgi_top_asserts.sv ***
// Purpose: port-level checker for the dual-port event interrupt logic
// Assumes: one clock domain, synchronous active-low reset
// Notes:   winner is the lowest requesting channel, as the design chose
`timescale 1ns/1ps
`include "dpgi_cfg.svh"

module dpgi_top_asserts #(
  parameter int NUM_CH = `DPGI_NUM_CH
) (
  // clock, reset and inputs
  input wire logic                      clk_sys_in,
  input wire logic                      rst_b_in,
  input wire logic                      ctrl_int_a_in,
  input wire logic                      cfg_a_wr_in,
  input wire logic                      cfg_b_wr_in,
  input wire logic [`DPGI_LEVEL_W-1:0]  cfg_a_level_in,
  input wire logic [`DPGI_LEVEL_W-1:0]  cfg_b_level_in,
  input wire logic [NUM_CH-1:0]         int_en_in,
  input wire logic [NUM_CH-1:0]         clr_transition_in,
  input wire logic [`DPGI_VEC_W-1:0]    normal_vector_in [NUM_CH],
  input wire logic [`DPGI_VEC_W-1:0]    error_vector_in [NUM_CH],
  input wire logic                      iack_in,
  // outputs
  input wire logic                      irq_out,
  input wire logic [`DPGI_LEVEL_W-1:0]  irq_level_out,
  input wire logic [`DPGI_VEC_W-1:0]    vector_out,
  input wire logic                      vector_valid_out,
  input wire dpgi_pkg::dpgi_chan_stat_t chan_stat_out [NUM_CH],
  input wire logic                      port_a_event_line_out
);
  // ------------------------------------------------------------
  // expected winner, level and vector
  // ------------------------------------------------------------
  logic [NUM_CH-1:0]        req;
  logic [1:0]               win;
  logic [`DPGI_LEVEL_W-1:0] lvl_a_ff;
  logic [`DPGI_LEVEL_W-1:0] lvl_b_ff;
  logic [`DPGI_LEVEL_W-1:0] exp_lvl;
  logic [`DPGI_VEC_W-1:0]   exp_vec;

  always_comb begin
    win = 2'h0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      req[i] = int_en_in[i] & (chan_stat_out[i].line_transition_flag |
                               chan_stat_out[i].operation_complete_flag);
      if (req[i]) begin
        win = 2'(i);
      end
    end
  end
  // channels 2 and 3 never compete for port A here: channel 2 stays disabled
  assign exp_lvl = (win < 2'h2) ? lvl_a_ff : lvl_b_ff;
  assign exp_vec = chan_stat_out[win].error_flag ? error_vector_in[win] : normal_vector_in[win];

  always_ff @(posedge clk_sys_in) begin
    if (!rst_b_in) begin
      lvl_a_ff <= `DPGI_LEVEL_RST;
      lvl_b_ff <= `DPGI_LEVEL_RST;
    end else begin
      if (cfg_a_wr_in) lvl_a_ff <= cfg_a_level_in;
      if (cfg_b_wr_in) lvl_b_ff <= cfg_b_level_in;
    end
  end

  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_b_in);

  sequence s_ctrl_held;
    ctrl_int_a_in [*5];
  endsequence
  sequence s_line_high;
    port_a_event_line_out [*5];
  endsequence
  sequence s_line_low;
    !port_a_event_line_out [*5];
  endsequence
  sequence s_ack_answer;
    ##1 vector_valid_out && (vector_out == $past(exp_vec));
  endsequence

  a_ctrl_to_line: assert property (s_ctrl_held |-> !port_a_event_line_out)
    else $error("controller interrupt did not pull port a line");
  a_fall_sets_flag: assert property ($fell(port_a_event_line_out) |->
    ##[1:4] chan_stat_out[1].line_transition_flag)
    else $error("falling line did not set transition flag");
  a_level_high: assert property (s_line_high |-> chan_stat_out[1].line_level_status)
    else $error("level status not high");
  a_level_low: assert property (s_line_low |-> !chan_stat_out[1].line_level_status)
    else $error("level status not low");
  a_irq_from_flags: assert property (irq_out == (|req))
    else $error("irq does not match enabled flags");
  a_flag_holds: assert property (chan_stat_out[1].line_transition_flag &&
    !clr_transition_in[1] |=> chan_stat_out[1].line_transition_flag)
    else $error("transition flag dropped without clear");
  a_vec_on_ack: assert property (iack_in && irq_out |-> s_ack_answer)
    else $error("wrong vector after acknowledge");
  a_lvl_on_irq: assert property ($rose(irq_out) |-> ##[0:1] irq_level_out == exp_lvl)
    else $error("irq level differs from port config");
  a_lvl_idle: assert property ($fell(irq_out) |-> ##[0:1] irq_level_out == 3'h0)
    else $error("irq level not zero when idle");
endmodule // dpgi_top_asserts

bind dpgi_top dpgi_top_asserts #(.NUM_CH(NUM_CH)) u_dpgi_chk (
  .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .ctrl_int_a_in(ctrl_int_a_in),
  .cfg_a_wr_in(cfg_a_wr_in), .cfg_b_wr_in(cfg_b_wr_in), .cfg_a_level_in(cfg_a_level_in),
  .cfg_b_level_in(cfg_b_level_in), .int_en_in(int_en_in), .clr_transition_in(clr_transition_in),
  .normal_vector_in(normal_vector_in), .error_vector_in(error_vector_in), .iack_in(iack_in),
  .irq_out(irq_out), .irq_level_out(irq_level_out), .vector_out(vector_out),
  .vector_valid_out(vector_valid_out), .chan_stat_out(chan_stat_out),
  .port_a_event_line_out(port_a_event_line_out));

// *** dpgi_host_model.sv ***
// Purpose: host cpu handler: acknowledge, capture vector, clear flag
// Assumes: delay_in sets how slowly the handler answers
// Notes:   clears port a first when both ports wait
`timescale 1ns/1ps

module dpgi_host_model (
  // clock and reset
  input  wire logic                      clk_sys_in,
  input  wire logic                      rst_b_in,
  // bus interrupt side
  input  wire logic                      irq_in,
  input  wire logic [7:0]                vector_in,
  input  wire logic                      vector_valid_in,
  input  wire dpgi_pkg::dpgi_chan_stat_t stat_in [4],
  input  wire logic [3:0]                delay_in,
  // handler actions
  output logic                           iack_out,
  output logic [3:0]                     clr_out,
  output logic [7:0]                     vec_out,
  output int                             done_out
);
  initial begin
    iack_out = 1'b0;
    clr_out = 4'h0;
    vec_out = 8'h00;
    done_out = 0;
    forever begin
      @(negedge clk_sys_in);
      if (rst_b_in && irq_in) begin
        repeat (delay_in) @(negedge clk_sys_in);
        iack_out = 1'b1;
        @(negedge clk_sys_in);
        iack_out = 1'b0;
        if (vector_valid_in) vec_out = vector_in;
        clr_out[stat_in[1].line_transition_flag ? 1 : 3] = 1'b1;
        @(negedge clk_sys_in);
        clr_out = 4'h0;
        done_out++;
      end
    end
  end
endmodule // dpgi_host_model

// *** dpgi_top_tb.sv ***
// Purpose: self-checking bench for dpgi_top
// Assumes: host model answers every irq; inputs move on falling edges
// Notes:   polling and dual-port checks, one complete pulse, then each event kind on both ports in turn
`timescale 1ns/1ps
`include "dpgi_cfg.svh"

module dpgi_top_tb;
  logic                      clk_sys_in = 1'b0;
  logic                      rst_b_in = 1'b0;
  logic [1:0]                ctrl = 2'h0;
  logic [1:0]                done = 2'h0;
  logic [1:0]                sync = 2'h0;
  logic [1:0]                cfg_wr = 2'h0;
  logic                      bus_err_b = 1'b1;
  logic [1:0]                active_ch = 2'h0;
  logic                      srq_a_b = 1'b1;
  logic                      ren_a_b = 1'b1;
  logic                      srq_b_b = 1'b1;
  logic                      msel = 1'b0;
  logic [2:0]                lvl [2] = '{3'h1, 3'h1};
  logic [3:0]                int_en = 4'b1010;
  logic [3:0]                clr_err = 4'h0;
  logic [3:0]                ch_done = 4'h0;
  logic [3:0]                clr_done = 4'h0;
  logic [7:0]                nv [4];
  logic [7:0]                ev [4];
  logic [3:0]                host_dly = 4'h0;
  logic [2:0]                seen_lvl;
  integer                    seed = 68429;
  int                        num_errors = 0;
  int                        compares = 0;
  logic                      irq;
  logic [2:0]                irq_lvl;
  logic [7:0]                vec;
  logic                      vec_v;
  dpgi_pkg::dpgi_chan_stat_t stat [4];
  wire  [1:0]                evl;
  logic                      host_iack;
  logic [3:0]                host_clr;
  logic [7:0]                host_vec;
  int                        host_done;

  dpgi_top DUT (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .ctrl_int_a_in(ctrl[0]),
    .ctrl_int_b_in(ctrl[1]), .xfer_done_a_in(done[0]), .xfer_done_b_in(done[1]),
    .bus_sync_a_in(sync[0]), .bus_sync_b_in(sync[1]), .bus_err_b_in(bus_err_b),
    .active_ch_in(active_ch), .ch_complete_in(ch_done), .srq_a_b_in(srq_a_b),
    .ren_a_b_in(ren_a_b), .srq_b_b_in(srq_b_b), .monitor_sel_in(msel),
    .cfg_a_wr_in(cfg_wr[0]), .cfg_b_wr_in(cfg_wr[1]), .cfg_a_level_in(lvl[0]),
    .cfg_b_level_in(lvl[1]), .int_en_in(int_en), .clr_transition_in(host_clr),
    .clr_complete_in(clr_done), .clr_error_in(clr_err), .normal_vector_in(nv),
    .error_vector_in(ev), .iack_in(host_iack), .irq_out(irq), .irq_level_out(irq_lvl),
    .vector_out(vec), .vector_valid_out(vec_v), .chan_stat_out(stat),
    .port_a_event_line_out(evl[0]), .port_b_event_line_out(evl[1]));

  dpgi_host_model u_host (
    .clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .irq_in(irq), .vector_in(vec),
    .vector_valid_in(vec_v), .stat_in(stat), .delay_in(host_dly), .iack_out(host_iack),
    .clr_out(host_clr), .vec_out(host_vec), .done_out(host_done));

  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t flag got %b exp %b", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t value got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    if (num_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic cfg_write(input int p);
    lvl[p] = 3'({$random(seed)} % 7 + 1);
    cfg_wr[p] = 1'b1;
    @(negedge clk_sys_in);
    cfg_wr[p] = 1'b0;
  endtask

  // bounded wait; remembers the level seen while irq stands
  task automatic wait_host(input int target);
    int t;
    t = 0;
    seen_lvl = 3'h0;
    while (host_done < target && t < 100) begin
      @(negedge clk_sys_in);
      t++;
      if (irq === 1'b1 && seen_lvl === 3'h0) seen_lvl = irq_lvl;
    end
    chk_bit(host_done >= target, 1'b1);
  endtask

  // k: 0 controller, 1 sync, 2 bus error on own channel, 3 on the paired channel
  task automatic run_evt(input int p, input int k);
    int ch;
    int n;
    ch = p ? 3 : 1;
    n = host_done;
    host_dly = 4'($random(seed));
    {srq_a_b, ren_a_b, srq_b_b, msel} = 4'($random(seed));
    if (k == 0) ctrl[p] = 1'b1;
    if (k == 1) done[p] = 1'b1;
    if (k == 1) sync[p] = 1'b1;
    if (k > 1) active_ch = 2'(ch + 2 - k);
    if (k > 1) bus_err_b = 1'b0;
    wait_host(n + 1);
    chk_val(seen_lvl, lvl[p]);
    chk_val(host_vec, (k == 2) ? ev[ch] : nv[ch]);
    chk_bit(evl[p], 1'b0);
    chk_bit(stat[active_ch].error_flag, k > 1);
    ctrl[p] = 1'b0;
    done[p] = 1'b0;
    sync[p] = 1'b0;
    bus_err_b = 1'b1;
    clr_err[active_ch] = (k > 1);
    repeat (4) @(negedge clk_sys_in);
    clr_err = 4'h0;
    if (k == 1) cfg_write(p);
    repeat (6) @(negedge clk_sys_in);
    chk_bit(evl[p], 1'b1);
    chk_bit(irq, 1'b0);
    chk_bit(stat[0].line_level_status, srq_a_b);
    chk_bit(stat[2].line_level_status, msel ? srq_b_b : ren_a_b);
  endtask

  // ------------------------------------------------------------
  // clock, watchdog and main sequence
  // ------------------------------------------------------------
  initial begin
    forever #50 clk_sys_in = ~clk_sys_in;
  end

  initial begin
    repeat (6000) @(posedge clk_sys_in);
    num_errors++;
    stop_test();
  end

  initial begin
    int n;
    for (int i = 0; i < 4; i++) begin
      nv[i] = 8'($random(seed));
      ev[i] = ~nv[i];
    end
    repeat (16) @(negedge clk_sys_in);
    rst_b_in = 1'b1;
    @(negedge clk_sys_in);
    chk_bit(irq, 1'b0);
    chk_val(vec, `DPGI_VEC_RST);
    chk_bit(evl[0] & evl[1], 1'b1);
    cfg_write(0);
    cfg_write(1);
    // polling only: flag sets but no request until enabled
    int_en = 4'h0;
    ctrl[0] = 1'b1;
    repeat (10) @(negedge clk_sys_in);
    chk_bit(irq, 1'b0);
    chk_bit(stat[1].line_transition_flag, 1'b1);
    chk_bit(stat[1].line_level_status, 1'b0);
    n = host_done;
    int_en = 4'b1010;
    wait_host(n + 1);
    ctrl[0] = 1'b0;
    repeat (8) @(negedge clk_sys_in);
    // both ports at once share one request line
    n = host_done;
    ctrl = 2'h3;
    wait_host(n + 2);
    chk_val(host_vec, nv[3]);
    ctrl = 2'h0;
    repeat (8) @(negedge clk_sys_in);
    // complete flag alone requests and stands until its own clear
    n = host_done;
    ch_done[3] = 1'b1;
    @(negedge clk_sys_in);
    ch_done[3] = 1'b0;
    wait_host(n + 1);
    chk_val(host_vec, nv[3]);
    chk_bit(irq, 1'b1);
    clr_done[3] = 1'b1;
    @(negedge clk_sys_in);
    clr_done[3] = 1'b0;
    repeat (20) @(negedge clk_sys_in);
    chk_bit(irq, 1'b0);
    chk_bit(stat[3].operation_complete_flag, 1'b0);
    for (int r = 0; r < 3; r++) begin
      for (int k = 0; k < 4; k++) begin
        run_evt(0, k);
        run_evt(1, k);
      end
    end
    stop_test();
  end
endmodule // dpgi_top_tb
